/* File: sms_modulator.sv */
// PWM or PDM modulator feeding the motor driver
module sms_modulator
    import sms_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] duty,
    input  wire logic       pdm_sel,
    input  wire logic       enable,
    output logic            motor_out
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [8:0] acc;
        logic       out;
    } sms_mod_t;

    sms_mod_t s_q, s_d;

    always_comb begin
        s_d     = s_q;
        s_d.cnt = s_q.cnt + 8'h01;
        // First-order sigma-delta: carry out is the density bit
        s_d.acc = {1'b0, s_q.acc[7:0]} + {1'b0, duty};
        if (!enable) begin
            s_d.out = 1'b0;
        end else if (pdm_sel) begin
            s_d.out = s_d.acc[8];
        end else begin
            s_d.out = s_q.cnt < duty;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign motor_out = s_q.out;

    default clocking mc @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_off_quiet: assert property (!enable |=> !motor_out)
        else $error("motor output active while disabled");
    a_pwm_zero: assert property (enable && !pdm_sel && duty == 8'h00
        |=> !motor_out)
        else $error("PWM pulse at zero duty");
endmodule : sms_modulator

/* File: sms_motor_model.sv */
// Motor driver and hall sensor model for the spindle servo bench
module sms_motor_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       motor_out,
    input  wire logic       motor_en,
    output logic [2:0]      hall_in,
    output logic [8:0]      duty_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [255:0] hist_q;
    logic [2:0]   ph_q;

    // Driver conducts only while enabled; one 256-clock window of drive
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hist_q <= '0;
            ph_q   <= 3'h0;
        end else begin
            hist_q <= {hist_q[254:0], motor_out & motor_en};
            ph_q   <= ph_q + 3'h1;
        end
    end

    assign duty_seen = 9'($countones(hist_q));

    // Sensors one clock apart, each toggling every 4 clocks
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic [2:0] p;
            p          = ph_q + 3'(i);
            hall_in[i] = p[2];
        end
    end
endmodule : sms_motor_model

/* File: sms_pkg.sv */
// Constants, register map and types of the spindle motor servo
package sms_pkg;
    // Loop sample period in system clocks
    localparam int unsigned SAMPLE_CLKS = 24;
    localparam logic [4:0]  TICK_LAST   = 5'(SAMPLE_CLKS - 1);
    localparam int unsigned CLK_MHZ     = 250;

    // Register offsets
    localparam logic [3:0] A_GAIN1    = 4'h0;
    localparam logic [3:0] A_GAIN2    = 4'h1;
    localparam logic [3:0] A_MULT     = 4'h2;
    localparam logic [3:0] A_CTRL     = 4'h3;
    localparam logic [3:0] A_INT_LO   = 4'h4;
    localparam logic [3:0] A_INT_HI   = 4'h5;
    localparam logic [3:0] A_FREQ_SET = 4'h6;
    localparam logic [3:0] A_FIFO_SET = 4'h7;
    localparam logic [3:0] A_STATUS2  = 4'h8;
    localparam logic [3:0] A_HGAIN    = 4'h9;
    localparam logic [3:0] A_HTRIP    = 4'hA;
    localparam logic [3:0] A_HCFG     = 4'hB;
    localparam logic [3:0] A_HMEAS    = 4'hC;

    // Field positions
    localparam int G1_KP_LSB  = 0;
    localparam int G1_KI_LSB  = 4;
    localparam int G2_KF_LSB  = 0;
    localparam int G2_SRC_LSB = 4;
    localparam int G2_SWA     = 6;
    localparam int G2_SWB     = 7;
    localparam int M_KI_LSB   = 0;
    localparam int M_KF_LSB   = 4;
    localparam int C_MODE_LSB = 0;
    localparam int C_PDM      = 2;
    localparam int C_OVERFLOW_OPENS_SWITCH_EN    = 3;
    localparam int ST_OVF     = 0;
    localparam int ST_TRIP    = 3;
    localparam int HC_SINGLE  = 0;
    localparam int HC_DIR     = 1;
    localparam int HM_FSAM    = 0;
    localparam int SHW        = 3;

    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;

    typedef enum logic [1:0] {
        MODE_SHUT   = 2'b00,
        MODE_START  = 2'b01,
        MODE_STOP   = 2'b10,
        MODE_CLOSED = 2'b11
    } sms_mode_t;

    typedef enum logic [1:0] {
        SRC_ZERO  = 2'b00,
        SRC_PLL   = 2'b01,
        SRC_TACHO = 2'b10,
        SRC_NONE  = 2'b11
    } sms_src_t;

    localparam logic [7:0] START_DUTY = 8'hE0;
    localparam logic [7:0] STOP_DUTY  = 8'h20;
    localparam logic [7:0] DUTY_MID   = 8'h80;

    localparam logic signed [23:0] SAT_MAX = 24'sh007FFF;
    localparam logic signed [23:0] SAT_MIN = 24'shFF8000;

    // Tacho measurement windows and filter
    localparam int TACHO_WIN_SHORT = 65536;
    localparam int TACHO_WIN_LONG  = 262144;
    localparam int FILT_SHIFT      = 2;
    localparam int FILT_FRAC       = 4;
endpackage : sms_pkg

/* File: sms_servo.sv */
// Spindle motor servo: PI loop, register file, tacho and modulator
//
// Contract
// - Programmable P, F, I gains plus scale register
// - Frequency scale passes one in 2^n samples
// - New loop sample every 24 clocks
// - Start, stop, closed loop and shutdown modes
// - Control register selects PDM or PWM
// - Start and stop drive fixed duty or density
// - Integrator shows speed during start and stop
// - Overflow flag readable in second status register
// - Overflow flag follows condition, not latched
// - Overflow opens loop switch when enabled
// - Integrator readable and writable by software
// - All switches open: integrator drives modulator
// - Closed loop regulates to frequency set point
// - Tacho measures hall rate, second-order filter
// - Filtered rate readable and selectable as input
// - Rate equals edges times programmed gain
// - One or three hall sensors counted
// - Sample select bit sets filter rate
// - Unsigned tacho rate compared with trip point
// - Trip crossing sets status bit 3
// - Config bit 1 picks trip direction
// - Frequency input PLL, tacho or zero; position FIFO
// - Switches give P, I or PI control
module sms_servo
    import sms_pkg::*;
#(
    parameter int WIN_SHORT = TACHO_WIN_SHORT,
    parameter int WIN_LONG  = TACHO_WIN_LONG
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic [7:0] pll_freq,
    input  wire logic [7:0] fifo_fill,
    input  wire logic [2:0] hall_in,
    output logic            motor_out,
    output logic            motor_en,
    output logic            overflow_flag
);
    typedef struct packed {
        logic [7:0]  gain1;
        logic [7:0]  gain2;
        logic [7:0]  mult;
        logic [7:0]  ctrl;
        logic [7:0]  freq_set;
        logic [7:0]  fifo_set;
        logic [7:0]  hgain;
        logic [7:0]  htrip;
        logic [7:0]  hcfg;
        logic        fsam;
        logic [15:0] integ;
        logic [7:0]  hi_snap;
        logic [7:0]  lo_stage;
        logic [4:0]  tick;
        logic [6:0]  sub;
        logic        ovf;
        logic        trip;
        logic        en;
        logic [7:0]  duty;
        logic [7:0]  rdata;
    } sms_state_t;

    sms_state_t s_q, s_d;

    logic [7:0]  rate;
    logic        trip_evt;
    logic        smp;
    sms_mode_t   mode;
    sms_src_t    src;
    logic [7:0]  freq_in;
    logic signed [8:0]  ferr;
    logic signed [8:0]  perr;
    logic signed [23:0] kf_t;
    logic signed [23:0] ki_t;
    logic signed [23:0] p_t;
    logic signed [23:0] sum_i;
    logic signed [23:0] sum_u;
    logic [16:0] sat_i;
    logic [16:0] sat_u;
    logic [15:0] u;
    logic        any_sat;
    logic        wr_int;

    // Clamp to 16-bit signed; top bit reports that clamping happened
    function automatic logic [16:0] sat16(input logic signed [23:0] v);
        if (v > SAT_MAX) begin
            return {1'b1, 16'h7FFF};
        end else if (v < SAT_MIN) begin
            return {1'b1, 16'h8000};
        end
        return {1'b0, v[15:0]};
    endfunction : sat16

    // Scale n keeps one sample in 2^n, down to 1 in 128
    function automatic logic sub_pass(input logic [6:0] sub,
                                      input logic [2:0] sc);
        logic [6:0] mask;
        mask = 7'((8'h01 << sc) - 8'h01);
        return (sub & mask) == 7'h00;
    endfunction : sub_pass

    assign mode   = sms_mode_t'(s_q.ctrl[C_MODE_LSB +: 2]);
    assign src    = sms_src_t'(s_q.gain2[G2_SRC_LSB +: 2]);
    assign smp    = s_q.tick == TICK_LAST;
    assign wr_int = reg_wr && (reg_addr == A_INT_LO || reg_addr == A_INT_HI);

    always_comb begin
        case (src)
            SRC_PLL:   freq_in = pll_freq;
            SRC_TACHO: freq_in = rate;
            SRC_ZERO:  freq_in = 8'h00;
            default:   freq_in = 8'h00;
        endcase
    end

    always_comb begin
        // Unsigned operands widened so the error never wraps
        ferr = $signed({1'b0, freq_in}) - $signed({1'b0, s_q.freq_set});
        perr = $signed({1'b0, fifo_fill}) - $signed({1'b0, s_q.fifo_set});
        kf_t = 24'sh000000;
        ki_t = 24'sh000000;
        if (sub_pass(s_q.sub, s_q.mult[M_KF_LSB +: SHW])) begin
            kf_t = 24'(ferr) <<< s_q.gain2[G2_KF_LSB +: SHW];
        end
        if (sub_pass(s_q.sub, s_q.mult[M_KI_LSB +: SHW])) begin
            ki_t = 24'(perr) <<< s_q.gain1[G1_KI_LSB +: SHW];
        end
        p_t   = 24'(perr) <<< s_q.gain1[G1_KP_LSB +: SHW];
        sum_i = 24'($signed(s_q.integ)) + kf_t + ki_t;
        sat_i = sat16(sum_i);
        // Switch B gates the integrator, switch A the proportional path
        if (s_q.gain2[G2_SWB]) begin
            sum_u = 24'($signed(sat_i[15:0]));
        end else begin
            sum_u = 24'($signed(s_q.integ));
        end
        if (s_q.gain2[G2_SWA]) begin
            sum_u = sum_u + p_t;
        end
        sat_u   = sat16(sum_u);
        u       = sat_u[15:0];
        any_sat = sat_u[16] || (s_q.gain2[G2_SWB] && sat_i[16]);
    end

    always_comb begin
        s_d       = s_q;
        s_d.rdata = 8'h00;
        s_d.tick  = smp ? 5'h00 : s_q.tick + 5'h01;
        s_d.en    = mode != MODE_SHUT;
        case (mode)
            MODE_START: begin
                s_d.duty = START_DUTY;
                s_d.ovf  = 1'b0;
            end
            MODE_STOP: begin
                s_d.duty = STOP_DUTY;
                s_d.ovf  = 1'b0;
            end
            MODE_CLOSED: begin
                if (smp) begin
                    s_d.sub  = s_q.sub + 7'h01;
                    s_d.duty = u[15:8] ^ DUTY_MID;
                    s_d.ovf  = any_sat;
                    if (s_q.gain2[G2_SWB]) begin
                        s_d.integ = sat_i[15:0];
                    end
                end
            end
            MODE_SHUT: begin
                s_d.duty = DUTY_MID;
                s_d.ovf  = 1'b0;
            end
            default: begin
                s_d.duty = DUTY_MID;
            end
        endcase
        // Open loop: integrator mirrors the speed input for monitoring
        if (smp && (mode == MODE_START || mode == MODE_STOP)) begin
            s_d.integ = {freq_in, 8'h00};
        end

        if (reg_rd) begin
            case (reg_addr)
                A_GAIN1:    s_d.rdata = s_q.gain1;
                A_GAIN2:    s_d.rdata = s_q.gain2;
                A_MULT:     s_d.rdata = s_q.mult;
                A_CTRL:     s_d.rdata = s_q.ctrl;
                A_INT_LO: begin
                    s_d.rdata   = s_q.integ[7:0];
                    // High byte frozen so a low-then-high read is coherent
                    s_d.hi_snap = s_q.integ[15:8];
                end
                A_INT_HI:   s_d.rdata = s_q.hi_snap;
                A_FREQ_SET: s_d.rdata = s_q.freq_set;
                A_FIFO_SET: s_d.rdata = s_q.fifo_set;
                A_STATUS2: begin
                    s_d.rdata[ST_OVF]  = s_q.ovf;
                    s_d.rdata[ST_TRIP] = s_q.trip;
                end
                A_HGAIN:    s_d.rdata = s_q.hgain;
                A_HTRIP:    s_d.rdata = s_q.htrip;
                A_HCFG:     s_d.rdata = s_q.hcfg;
                A_HMEAS:    s_d.rdata = rate;
                default:    s_d.rdata = 8'h00;
            endcase
        end

        if (reg_wr) begin
            case (reg_addr)
                A_GAIN1:    s_d.gain1 = reg_wdata;
                A_GAIN2:    s_d.gain2 = reg_wdata;
                A_MULT:     s_d.mult = reg_wdata;
                A_CTRL:     s_d.ctrl = reg_wdata;
                A_INT_LO:   s_d.lo_stage = reg_wdata;
                A_INT_HI:   s_d.integ = {reg_wdata, s_q.lo_stage};
                A_FREQ_SET: s_d.freq_set = reg_wdata;
                A_FIFO_SET: s_d.fifo_set = reg_wdata;
                A_STATUS2: begin
                    if (reg_wdata[ST_TRIP]) begin
                        s_d.trip = 1'b0;
                    end
                end
                A_HGAIN:    s_d.hgain = reg_wdata;
                A_HTRIP:    s_d.htrip = reg_wdata;
                A_HCFG:     s_d.hcfg = reg_wdata;
                A_HMEAS:    s_d.fsam = reg_wdata[HM_FSAM];
                default: begin
                end
            endcase
        end

        // Set after clear, so a trip in the clearing cycle survives
        if (trip_evt) begin
            s_d.trip = 1'b1;
        end
        // Hardware opening beats a software write for safety
        if (s_q.ovf && s_q.ctrl[C_OVERFLOW_OPENS_SWITCH_EN]) begin
            s_d.gain2[G2_SWB] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.duty <= DUTY_MID;
        end else begin
            s_q <= s_d;
        end
    end

    sms_tacho #(
        .WIN_SHORT (WIN_SHORT),
        .WIN_LONG  (WIN_LONG)
    ) u_tacho (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .hall_in   (hall_in),
        .gain      (s_q.hgain),
        .trip_pt   (s_q.htrip),
        .single    (s_q.hcfg[HC_SINGLE]),
        .dir_below (s_q.hcfg[HC_DIR]),
        .fs_sel    (s_q.fsam),
        .rate      (rate),
        .trip_evt  (trip_evt)
    );

    sms_modulator u_mod (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .duty      (s_q.duty),
        .pdm_sel   (s_q.ctrl[C_PDM]),
        .enable    (s_q.en),
        .motor_out (motor_out)
    );

    assign reg_rdata     = s_q.rdata;
    assign motor_en      = s_q.en;
    assign overflow_flag = s_q.ovf;

    default clocking sc @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_sample_period: assert property (smp |=> !smp ##23 smp)
        else $error("loop sample period is not 24 clocks");
    a_ovf_clears: assert property (smp && mode == MODE_CLOSED
        && !any_sat |=> !overflow_flag)
        else $error("overflow flag held after condition cleared");
    a_ovf_opens: assert property (overflow_flag && s_q.ctrl[C_OVERFLOW_OPENS_SWITCH_EN]
        |=> !s_q.gain2[G2_SWB])
        else $error("overflow did not open switch");
    a_start_duty: assert property (mode == MODE_START
        |=> s_q.duty == START_DUTY && motor_en)
        else $error("start mode duty wrong");
    a_shut_off: assert property (mode == MODE_SHUT |=> !motor_en)
        else $error("drive enabled in shutdown");
    a_bypass_dac: assert property (smp && mode == MODE_CLOSED
        && !s_q.gain2[G2_SWA] && !s_q.gain2[G2_SWB] && !wr_int
        |=> s_q.duty == (s_q.integ[15:8] ^ DUTY_MID))
        else $error("bypass does not pass integrator");
    a_int_write: assert property (reg_wr && reg_addr == A_INT_HI
        |=> s_q.integ == {$past(reg_wdata), $past(s_q.lo_stage)})
        else $error("integrator write lost");
    a_int_read: assert property (reg_rd && reg_addr == A_INT_LO
        |=> reg_rdata == $past(s_q.integ[7:0]) ##1 reg_rdata == 8'h00
        || $past(reg_rd))
        else $error("integrator read wrong");
    a_trip_sticky: assert property (trip_evt |=> s_q.trip)
        else $error("trip event not recorded");
    a_stop_duty: assert property (mode == MODE_STOP
        |=> s_q.duty == STOP_DUTY && motor_en)
        else $error("stop mode duty wrong");
    a_ovf_open_loop: assert property (mode != MODE_CLOSED
        |=> !overflow_flag)
        else $error("overflow flag set outside closed loop");
    a_status_ovf: assert property (reg_rd && reg_addr == A_STATUS2
        |=> reg_rdata[ST_OVF] == $past(overflow_flag))
        else $error("status overflow bit differs from flag");
    a_open_mirror: assert property (smp && (mode == MODE_START
        || mode == MODE_STOP) && !wr_int
        |=> s_q.integ == {$past(freq_in), 8'h00})
        else $error("integrator does not mirror speed input");
    a_integ_hold: assert property (mode == MODE_CLOSED
        && !s_q.gain2[G2_SWB] && !wr_int |=> $stable(s_q.integ))
        else $error("integrator moved with switch B open");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read");

    c_overflow: cover property (overflow_flag && s_q.ctrl[C_OVERFLOW_OPENS_SWITCH_EN]);
    c_trip: cover property (trip_evt);
    c_bypass: cover property (mode == MODE_CLOSED && smp
        && !s_q.gain2[G2_SWA] && !s_q.gain2[G2_SWB]);
    c_pi_loop: cover property (mode == MODE_CLOSED && smp
        && s_q.gain2[G2_SWA] && s_q.gain2[G2_SWB]);
    c_start: cover property (mode == MODE_START && smp);
endmodule : sms_servo

/* File: sms_tacho.sv */
// Hall sensor frequency meter with second-order filter and trip event
module sms_tacho
    import sms_pkg::*;
#(
    parameter int WIN_SHORT = TACHO_WIN_SHORT,
    parameter int WIN_LONG  = TACHO_WIN_LONG
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [2:0] hall_in,
    input  wire logic [7:0] gain,
    input  wire logic [7:0] trip_pt,
    input  wire logic       single,
    input  wire logic       dir_below,
    input  wire logic       fs_sel,
    output logic [7:0]      rate,
    output logic            trip_evt
);
    typedef struct packed {
        logic [2:0]  h1;
        logic [2:0]  h2;
        logic [2:0]  h3;
        logic [17:0] win;
        logic [7:0]  edges;
        logic [11:0] y1;
        logic [11:0] y2;
        logic [7:0]  rate;
        logic        trip;
    } sms_tach_t;

    sms_tach_t s_q, s_d;
    logic [2:0]  ed;
    logic [1:0]  cnt;
    logic [8:0]  esum;
    logic [15:0] raw;
    logic [7:0]  x;
    logic        last;
    logic signed [12:0] dif1, dif2;

    always_comb begin
        s_d      = s_q;
        s_d.h1   = hall_in;
        s_d.h2   = s_q.h1;
        s_d.h3   = s_q.h2;
        s_d.trip = 1'b0;
        ed  = s_q.h2 ^ s_q.h3;
        if (single) begin
            ed = ed & 3'b001;
        end
        // Both edges count, giving twice the sensor count per turn
        cnt  = 2'(ed[0]) + 2'(ed[1]) + 2'(ed[2]);
        esum = {1'b0, s_q.edges} + {7'h00, cnt};
        // Compare by >= so a shorter window ends at once after a switch
        last = fs_sel ? (s_q.win >= 18'(WIN_LONG - 1))
                      : (s_q.win >= 18'(WIN_SHORT - 1));
        raw  = 16'(s_q.edges) * 16'(gain);
        x    = (raw > 16'h00FF) ? 8'hFF : raw[7:0];
        dif1 = 13'({x, 4'h0}) - 13'(s_q.y1);
        dif2 = 13'(s_q.y1) - 13'(s_q.y2);
        if (last) begin
            s_d.win   = '0;
            s_d.edges = {6'h00, cnt};
            // Two cascaded first-order low-pass stages
            // Signed sum keeps the shift arithmetic when the rate falls
            s_d.y1 = 12'($signed({1'b0, s_q.y1})
                         + (dif1 >>> FILT_SHIFT));
            s_d.y2 = 12'($signed({1'b0, s_q.y2})
                         + (dif2 >>> FILT_SHIFT));
            s_d.rate = s_d.y2[11:FILT_FRAC];
            if (dir_below) begin
                s_d.trip = s_q.rate >= trip_pt && s_d.rate < trip_pt;
            end else begin
                s_d.trip = s_q.rate <= trip_pt && s_d.rate > trip_pt;
            end
        end else begin
            s_d.win   = s_q.win + 18'h00001;
            s_d.edges = esum[8] ? 8'hFF : esum[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rate     = s_q.rate;
    assign trip_evt = s_q.trip;

    default clocking tc @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_trip_above: assert property (trip_evt && !$past(dir_below)
        |-> rate > $past(trip_pt))
        else $error("upward trip without crossing");
    a_trip_below: assert property (trip_evt && $past(dir_below)
        |-> rate < $past(trip_pt))
        else $error("downward trip without crossing");
endmodule : sms_tacho

/* File: spindle_motor_servo_tacho_tb_top.sv */
// Self-checking bench for the spindle motor servo
module spindle_motor_servo_tacho_tb_top import sms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] CTL [5] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h00};
    localparam logic [7:0] DUTY [5] = '{START_DUTY, STOP_DUTY, START_DUTY,
                                        STOP_DUTY, 8'h00};
    localparam logic [2:0] SUB [3]  = '{3'h0, 3'h3, 3'h7};
    localparam logic [3:0] RMAP [3] = '{A_GAIN1, A_MULT, A_FREQ_SET};

    logic        sys_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic [3:0]  reg_addr  = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [7:0]  pll_freq  = 8'h00;
    logic [7:0]  fifo_fill = 8'h00;
    logic [7:0]  reg_rdata;
    logic [2:0]  hall_in;
    logic        motor_out;
    logic        motor_en;
    logic        overflow_flag;
    logic [8:0]  duty_seen;
    logic [15:0] v0;
    logic [15:0] v1;
    logic [7:0]  rv;
    int          fails   = 0;
    int          n_tests = 0;
    int          cyc     = 0;

    always #2 sys_clk = ~sys_clk;

    // Short tacho windows keep the filter settling time small
    sms_servo #(.WIN_SHORT(16), .WIN_LONG(64)) u_dut (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .pll_freq      (pll_freq),
        .fifo_fill     (fifo_fill),
        .hall_in       (hall_in),
        .motor_out     (motor_out),
        .motor_en      (motor_en),
        .overflow_flag (overflow_flag)
    );

    sms_motor_model u_motor (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .motor_out (motor_out),
        .motor_en  (motor_en),
        .hall_in   (hall_in),
        .duty_seen (duty_seen)
    );

    task automatic conclude();
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the read edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // Low byte first: it freezes the high byte
    task automatic rd16(output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(A_INT_LO, lo);
        rd(A_INT_HI, hi);
        v = {hi, lo};
    endtask : rd16

    task automatic wr16(input logic [15:0] v);
        wr(A_INT_LO, v[7:0]);
        wr(A_INT_HI, v[15:8]);
    endtask : wr16

    task automatic chkreg(input logic [3:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        rd(a, rv);
        chk({8'h00, rv & m}, {8'h00, e});
    endtask : chkreg

    // Filter truncation may leave the rate up to two counts short
    task automatic chkrng(input logic [7:0] v, input logic [7:0] x);
        chk(16'(v >= x - 8'h02 && v <= x), 16'h0001);
    endtask : chkrng

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            $display("ERROR at %0t: run did not finish", $time);
            conclude();
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk(16'(motor_en), 16'h0000);
        for (int a = 0; a < 14; a++) chkreg(4'(a), 8'hFF, RST_REG);
        for (int i = 0; i < 3; i++) begin
            wr(RMAP[i], 8'h75);
            chkreg(RMAP[i], 8'h77, 8'h75);
        end
        pll_freq <= 8'h5A;
        wr(A_GAIN2, 8'h10);
        wr(A_CTRL, 8'h01);
        repeat (50) @(posedge sys_clk);
        rd16(v0);
        chk(v0, 16'h5A00);
        for (int i = 0; i < 5; i++) begin
            wr(A_CTRL, CTL[i]);
            repeat (300) @(posedge sys_clk);
            chk(16'(duty_seen), 16'(DUTY[i]));
        end
        chk(16'(motor_en), 16'h0000);
        wr(A_GAIN2, 8'h00);
        wr(A_CTRL, 8'h03);
        wr16(16'h1234);
        rd16(v0);
        chk(v0, 16'h1234);
        repeat (300) @(posedge sys_clk);
        chk(16'(duty_seen), 16'h0092);
        wr(A_CTRL, 8'h07);
        repeat (300) @(posedge sys_clk);
        chk(16'(duty_seen), 16'h0092);
        // Frequency error of one count, integral path only
        pll_freq <= 8'h41;
        wr(A_FREQ_SET, 8'h40);
        wr(A_GAIN2, 8'h90);
        for (int i = 0; i < 3; i++) begin
            wr(A_MULT, {1'b0, SUB[i], 4'h0});
            wr16(16'h0000);
            rd16(v0);
            repeat (3068) @(posedge sys_clk);
            rd16(v1);
            chk(v1 - v0, 16'(128 >> SUB[i]));
        end
        pll_freq <= 8'hFF;
        wr(A_FREQ_SET, 8'h00);
        wr(A_MULT, 8'h00);
        wr(A_GAIN2, 8'h97);
        repeat (100) @(posedge sys_clk);
        chk(16'(overflow_flag), 16'h0001);
        chkreg(A_STATUS2, 8'h01, 8'h01);
        rd16(v0);
        chk(v0, 16'h7FFF);
        chkreg(A_GAIN2, 8'hFF, 8'h97);
        wr(A_CTRL, 8'h0B);
        repeat (72) @(posedge sys_clk);
        chkreg(A_GAIN2, 8'hFF, 8'h17);
        chk(16'(overflow_flag), 16'h0000);
        chkreg(A_STATUS2, 8'h01, 8'h00);
        // Proportional path alone, then both switches closed
        fifo_fill <= 8'h50;
        wr(A_FIFO_SET, 8'h40);
        wr(A_GAIN1, 8'h04);
        wr16(16'h0000);
        wr(A_GAIN2, 8'h40);
        repeat (300) @(posedge sys_clk);
        chk(16'(duty_seen), 16'h0081);
        wr(A_GAIN2, 8'hC0);
        rd16(v0);
        repeat (3068) @(posedge sys_clk);
        rd16(v1);
        chk(v1 - v0, 16'h0800);
        wr(A_CTRL, 8'h00);
        wr(A_HGAIN, 8'h0A);
        wr(A_HTRIP, 8'h64);
        wr(A_HCFG, 8'h01);
        repeat (2000) @(posedge sys_clk);
        rd(A_HMEAS, rv);
        chkrng(rv, 8'h28);
        wr(A_STATUS2, 8'h08);
        chkreg(A_STATUS2, 8'h08, 8'h00);
        wr(A_HCFG, 8'h00);
        repeat (2000) @(posedge sys_clk);
        rd(A_HMEAS, rv);
        chkrng(rv, 8'h78);
        chkreg(A_STATUS2, 8'h08, 8'h08);
        wr(A_STATUS2, 8'h08);
        wr(A_HCFG, 8'h03);
        repeat (2000) @(posedge sys_clk);
        chkreg(A_STATUS2, 8'h08, 8'h08);
        wr(A_HMEAS, 8'h01);
        repeat (6000) @(posedge sys_clk);
        rd(A_HMEAS, rv);
        chkrng(rv, 8'hA0);
        wr(A_GAIN2, 8'h20);
        wr(A_CTRL, 8'h01);
        repeat (50) @(posedge sys_clk);
        rd16(v0);
        chkrng(v0[15:8], 8'hA0);
        conclude();
    end
endmodule : spindle_motor_servo_tacho_tb_top
